/* File: shared/fagm_defines.svh */
// Constants for the fault alert group masking block.
`ifndef FAGM_DEFINES_SVH
`define FAGM_DEFINES_SVH

`define FAGM_ADDR_W 16
`define FAGM_DATA_W 32
`define FAGM_STRB_W 4
`define FAGM_GRP_N 8

// Register indices; byte address is four times the index.
`define FAGM_MASK_IDX 16'h0016
`define FAGM_ACT_IDX 16'h0018
`define FAGM_IST_IDX 16'h0019
`define FAGM_IMSK_IDX 16'h001a

`define FAGM_MASK_RST 8'h00
`define FAGM_IST_RST 8'h00
`define FAGM_IMSK_RST 8'h00

`define FAGM_BIT_PROT 7
`define FAGM_BIT_UT 6
`define FAGM_BIT_OT 5
`define FAGM_BIT_UV 4
`define FAGM_BIT_OV 3
`define FAGM_BIT_COMP 2
`define FAGM_BIT_SYS 1
`define FAGM_BIT_PWR 0

`define FAGM_PROT_W 16
`define FAGM_REG_W 8

`define FAGM_RESP_OKAY 2'h0
`define FAGM_RESP_SLVERR 2'h2

`endif

/* File: shared/fagm_pkg.sv */
// Types shared by the fault alert group masking block.
`default_nettype none
`include "fagm_defines.svh"
package fagm_pkg;

  typedef logic [`FAGM_GRP_N-1:0] fagm_grp_t;

  typedef struct packed {
    logic [`FAGM_PROT_W-1:0] protector_fault_status;
    logic [`FAGM_REG_W-1:0] undertemp_fault_status;
    logic [`FAGM_REG_W-1:0] overtemp_fault_status;
    logic [`FAGM_REG_W-1:0] undervolt_fault_status;
    logic [`FAGM_REG_W-1:0] overvolt_fault_status;
    logic [`FAGM_REG_W-1:0] compare_diag_fault_status;
    logic [`FAGM_REG_W-1:0] system_fault_status;
    logic [`FAGM_REG_W-1:0] power_fault_status_one;
    logic [`FAGM_REG_W-1:0] power_fault_status_two;
    logic [`FAGM_REG_W-1:0] power_fault_status_three;
  } fagm_fault_s;

  typedef struct packed {
    logic en;
    logic [`FAGM_ADDR_W-1:0] addr;
    logic [`FAGM_DATA_W-1:0] data;
    logic [`FAGM_STRB_W-1:0] strb;
  } fagm_wcmd_s;

  typedef enum logic [0:0] {
    FAGM_BUS_IDLE = 1'b0,
    FAGM_BUS_RESP = 1'b1
  } fagm_bus_e;

endpackage : fagm_pkg
`default_nettype wire

/* File: core/fagm_axil_slave.sv */
// AXI4-Lite slave front end for the fault alert masking registers.
`default_nettype none
`include "fagm_defines.svh"
module fagm_axil_slave
  import fagm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [`FAGM_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`FAGM_DATA_W-1:0] wdata,
  input wire logic [`FAGM_STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`FAGM_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [`FAGM_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output fagm_wcmd_s wcmd,
  input wire logic wr_ok,
  output logic [`FAGM_ADDR_W-1:0] rd_addr,
  input wire logic [`FAGM_DATA_W-1:0] rd_data,
  input wire logic rd_ok
);

  fagm_bus_e wr_state;
  fagm_bus_e rd_state;
  logic aw_held;
  logic w_held;
  logic [`FAGM_ADDR_W-1:0] aw_addr;
  logic [`FAGM_DATA_W-1:0] w_data;
  logic [`FAGM_STRB_W-1:0] w_strb;

  // Valids are masked by ce so that a frozen slave never completes a beat.
  assign awready = ce && !aw_held && wr_state == FAGM_BUS_IDLE;
  assign wready = ce && !w_held && wr_state == FAGM_BUS_IDLE;
  assign arready = ce && rd_state == FAGM_BUS_IDLE;
  assign bvalid = ce && wr_state == FAGM_BUS_RESP;
  assign rvalid = ce && rd_state == FAGM_BUS_RESP;
  assign rd_addr = araddr;

  assign wcmd.en = ce && aw_held && w_held && wr_state == FAGM_BUS_IDLE;
  assign wcmd.addr = aw_addr;
  assign wcmd.data = w_data;
  assign wcmd.strb = w_strb;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (awvalid && awready) begin
      aw_held <= 1'b1;
      aw_addr <= awaddr;
    end else if (wcmd.en) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end else if (wvalid && wready) begin
      w_held <= 1'b1;
      w_data <= wdata;
      w_strb <= wstrb;
    end else if (wcmd.en) begin
      w_held <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state <= FAGM_BUS_IDLE;
      bresp <= `FAGM_RESP_OKAY;
    end else if (ce) begin
      case (wr_state)
        FAGM_BUS_IDLE: begin
          if (wcmd.en) begin
            wr_state <= FAGM_BUS_RESP;
            bresp <= wr_ok ? `FAGM_RESP_OKAY : `FAGM_RESP_SLVERR;
          end
        end
        default: begin
          if (bready) begin
            wr_state <= FAGM_BUS_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= FAGM_BUS_IDLE;
      rdata <= '0;
      rresp <= `FAGM_RESP_OKAY;
    end else if (ce) begin
      case (rd_state)
        FAGM_BUS_IDLE: begin
          if (arvalid) begin
            rd_state <= FAGM_BUS_RESP;
            rdata <= rd_data;
            rresp <= rd_ok ? `FAGM_RESP_OKAY : `FAGM_RESP_SLVERR;
          end
        end
        default: begin
          if (rready) begin
            rd_state <= FAGM_BUS_IDLE;
          end
        end
      endcase
    end
  end

endmodule : fagm_axil_slave
`default_nettype wire

/* File: core/fagm_alert_merge.sv */
// Per-group fault summary and masked alert merge.
`default_nettype none
`include "fagm_defines.svh"
module fagm_alert_merge
  import fagm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire fagm_fault_s faults,
  input wire fagm_grp_t mask,
  output fagm_grp_t grp_active,
  output logic alert
);

  fagm_grp_t next_active;

  // Status bits are only observed here; nothing in this block writes them.
  always_comb begin
    next_active = '0;
    next_active[`FAGM_BIT_PROT] = |faults.protector_fault_status;
    next_active[`FAGM_BIT_UT] = |faults.undertemp_fault_status;
    next_active[`FAGM_BIT_OT] = |faults.overtemp_fault_status;
    next_active[`FAGM_BIT_UV] = |faults.undervolt_fault_status;
    next_active[`FAGM_BIT_OV] = |faults.overvolt_fault_status;
    next_active[`FAGM_BIT_COMP] = |faults.compare_diag_fault_status;
    next_active[`FAGM_BIT_SYS] = |faults.system_fault_status;
    next_active[`FAGM_BIT_PWR] = |{faults.power_fault_status_one,
                                   faults.power_fault_status_two,
                                   faults.power_fault_status_three};
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grp_active <= '0;
    end else if (ce) begin
      grp_active <= next_active;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert <= 1'b0;
    end else if (ce) begin
      alert <= |(grp_active & ~mask);
    end
  end

endmodule : fagm_alert_merge
`default_nettype wire

/* File: core/fagm_top.sv */
// Top of the fault alert group masking block with its register file.
`default_nettype none
`include "fagm_defines.svh"
module fagm_top
  import fagm_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  input wire logic [`FAGM_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [`FAGM_DATA_W-1:0] wdata,
  input wire logic [`FAGM_STRB_W-1:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`FAGM_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [`FAGM_DATA_W-1:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire fagm_fault_s faults,
  output logic fault_alert_req,
  output logic fault_alert_pin_n,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////

  function automatic logic [`FAGM_ADDR_W-1:0] fagm_byte_addr(
    input logic [`FAGM_ADDR_W-1:0] idx
  );
    return {idx[`FAGM_ADDR_W-3:0], 2'h0};
  endfunction : fagm_byte_addr

  function automatic logic fagm_hit(
    input logic [`FAGM_ADDR_W-1:0] addr,
    input logic [`FAGM_ADDR_W-1:0] idx
  );
    return addr == fagm_byte_addr(idx);
  endfunction : fagm_hit

  ////////////////////////////////////////////////////////////////////////////

  fagm_grp_t fault_alert_mask_primary;
  fagm_grp_t grp_active;
  fagm_grp_t grp_prev;
  fagm_grp_t new_ev;
  fagm_grp_t irq_status;
  fagm_grp_t irq_mask;
  fagm_grp_t w1c;
  fagm_grp_t next_irq_status;
  fagm_wcmd_s wcmd;
  logic wr_ok;
  logic [`FAGM_ADDR_W-1:0] rd_addr;
  logic [`FAGM_DATA_W-1:0] rd_data;
  logic rd_ok;
  logic wr_mask;
  logic wr_ist;
  logic wr_imsk;
  logic alert;

  fagm_axil_slave u_slave (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wcmd(wcmd),
    .wr_ok(wr_ok),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  fagm_alert_merge u_merge (
    .aclk(aclk),
    .aresetn(aresetn),
    .ce(ce),
    .faults(faults),
    .mask(fault_alert_mask_primary),
    .grp_active(grp_active),
    .alert(alert)
  );

  ////////////////////////////////////////////////////////////////////////////

  // The pin is open-drain style active low; the request is its positive form.
  assign fault_alert_req = alert;
  assign fault_alert_pin_n = ~alert;

  ////////////////////////////////////////////////////////////////////////////

  // Only byte lane 0 carries register bits, so only its strobe enables writes.
  always_comb begin
    wr_mask = 1'b0;
    wr_ist = 1'b0;
    wr_imsk = 1'b0;
    wr_ok = 1'b1;
    if (fagm_hit(wcmd.addr, `FAGM_MASK_IDX)) begin
      wr_mask = wcmd.en && wcmd.strb[0];
    end else if (fagm_hit(wcmd.addr, `FAGM_ACT_IDX)) begin
      wr_ok = 1'b1;
    end else if (fagm_hit(wcmd.addr, `FAGM_IST_IDX)) begin
      wr_ist = wcmd.en && wcmd.strb[0];
    end else if (fagm_hit(wcmd.addr, `FAGM_IMSK_IDX)) begin
      wr_imsk = wcmd.en && wcmd.strb[0];
    end else begin
      wr_ok = 1'b0;
    end
  end

  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    if (fagm_hit(rd_addr, `FAGM_MASK_IDX)) begin
      rd_data[`FAGM_GRP_N-1:0] = fault_alert_mask_primary;
    end else if (fagm_hit(rd_addr, `FAGM_ACT_IDX)) begin
      rd_data[`FAGM_GRP_N-1:0] = grp_active;
    end else if (fagm_hit(rd_addr, `FAGM_IST_IDX)) begin
      rd_data[`FAGM_GRP_N-1:0] = irq_status;
    end else if (fagm_hit(rd_addr, `FAGM_IMSK_IDX)) begin
      rd_data[`FAGM_GRP_N-1:0] = irq_mask;
    end else begin
      rd_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // A mask write steers only the alert path; fault status is never touched.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fault_alert_mask_primary <= `FAGM_MASK_RST;
    end else if (ce && wr_mask) begin
      fault_alert_mask_primary <= wcmd.data[`FAGM_GRP_N-1:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask <= `FAGM_IMSK_RST;
    end else if (ce && wr_imsk) begin
      irq_mask <= wcmd.data[`FAGM_GRP_N-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////

  // A group turning active is the event; set beats a same-cycle clear.
  assign new_ev = grp_active & ~grp_prev;
  assign w1c = wr_ist ? wcmd.data[`FAGM_GRP_N-1:0] : '0;
  assign next_irq_status = (irq_status & ~w1c) | new_ev;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      grp_prev <= '0;
    end else if (ce) begin
      grp_prev <= grp_active;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_status <= `FAGM_IST_RST;
    end else if (ce) begin
      irq_status <= next_irq_status;
    end
  end

  assign irq = |(irq_status & irq_mask);

  ////////////////////////////////////////////////////////////////////////////

  default clocking fagm_cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  prot_gate_a: assert property (
    ce && grp_active[`FAGM_BIT_PROT]
    && !fault_alert_mask_primary[`FAGM_BIT_PROT]
    |=> fault_alert_req)
    else $error("Unmasked protector group did not raise the alert.");

  ut_gate_a: assert property (
    ce && grp_active[`FAGM_BIT_UT] && !fault_alert_mask_primary[`FAGM_BIT_UT]
    |-> ##1 fault_alert_req && !fault_alert_pin_n == 1'b1)
    else $error("Unmasked undertemperature group did not raise the alert.");

  ot_gate_a: assert property (
    ce && grp_active[`FAGM_BIT_OT] && !fault_alert_mask_primary[`FAGM_BIT_OT]
    |=> !fault_alert_pin_n)
    else $error("Unmasked overtemperature group did not drive the pin low.");

  uv_gate_a: assert property (
    ce && grp_active[`FAGM_BIT_UV] && !fault_alert_mask_primary[`FAGM_BIT_UV]
    |=> fault_alert_req)
    else $error("Unmasked undervoltage group did not raise the alert.");

  ov_gate_a: assert property (
    ce && grp_active[`FAGM_BIT_OV] && !fault_alert_mask_primary[`FAGM_BIT_OV]
    |=> fault_alert_req)
    else $error("Unmasked overvoltage group did not raise the alert.");

  comp_gate_a: assert property (
    ce && grp_active[`FAGM_BIT_COMP]
    && !fault_alert_mask_primary[`FAGM_BIT_COMP]
    |=> fault_alert_req)
    else $error("Unmasked comparison group did not raise the alert.");

  sys_gate_a: assert property (
    ce && grp_active[`FAGM_BIT_SYS] && !fault_alert_mask_primary[`FAGM_BIT_SYS]
    |=> fault_alert_req)
    else $error("Unmasked system group did not raise the alert.");

  pwr_gate_a: assert property (
    ce && (|faults.power_fault_status_three)
    && !fault_alert_mask_primary[`FAGM_BIT_PWR]
    ##1 ce && !fault_alert_mask_primary[`FAGM_BIT_PWR]
    |=> fault_alert_req)
    else $error("Unmasked third power register did not raise the alert.");

  alert_or_a: assert property (
    ce |=> fault_alert_req == |($past(grp_active)
                                & ~$past(fault_alert_mask_primary)))
    else $error("Alert is not the OR of the unmasked groups.");

  all_masked_a: assert property (
    (ce && &fault_alert_mask_primary) [*2] |=> !fault_alert_req)
    else $error("Alert raised while every group was masked.");

  mask_quiet_a: assert property (
    ce && wr_mask && $stable(faults) |=> grp_active == $past(grp_active))
    else $error("Mask write disturbed the group status.");

  mask_write_a: assert property (
    ce && wr_mask
    |=> fault_alert_mask_primary == $past(wcmd.data[`FAGM_GRP_N-1:0]))
    else $error("Mask register did not take the written value.");

  event_set_a: assert property (
    ce && new_ev != '0 |=> (irq_status & $past(new_ev)) == $past(new_ev))
    else $error("Group event was lost from the interrupt status.");

  irq_level_a: assert property (
    ce && (irq_status & irq_mask) == '0 && new_ev == '0 && !wr_imsk
    ##1 ce |-> !irq)
    else $error("Interrupt raised with no unmasked status bit.");

  write_resp_a: assert property (
    awvalid && awready && wvalid && wready ##1 ce |=> bvalid)
    else $error("Write response did not follow two cycles after the beats.");

  read_resp_a: assert property (
    arvalid && arready ##1 ce |-> rvalid)
    else $error("Read data did not follow one cycle after the address.");

  unmasked_only_a: assert property (
    ce && (grp_active & ~fault_alert_mask_primary) == '0
    |=> !fault_alert_req)
    else $error("Alert raised with every active group masked.");

  pin_level_a: assert property (
    fault_alert_pin_n == !fault_alert_req)
    else $error("Alert pin is not the inverse of the request.");

  power_group_a: assert property (
    ce && (|faults.power_fault_status_two) |=> grp_active[`FAGM_BIT_PWR])
    else $error("Second power register did not mark the power group.");

  // A low enable must hold every register and hide every handshake.
  freeze_state_a: assert property (
    !ce |=> $stable(fault_alert_req) && $stable(irq_status)
    && $stable(fault_alert_mask_primary) && $stable(irq_mask))
    else $error("State moved while the clock enable was low.");

  ready_gate_a: assert property (
    !ce |-> !awready && !wready && !arready && !bvalid && !rvalid)
    else $error("Handshake output high while the clock enable was low.");

  busy_refuse_a: assert property (
    bvalid |-> !awready && !wready)
    else $error("Write accepted while a response was pending.");

  bresp_hold_a: assert property (
    bvalid && !bready |=> !ce || bvalid && $stable(bresp))
    else $error("Write response dropped before it was taken.");

  rdata_hold_a: assert property (
    rvalid && !rready |=> !ce || rvalid && $stable(rdata) && $stable(rresp))
    else $error("Read data changed before it was taken.");

  slverr_zero_a: assert property (
    rvalid && rresp == `FAGM_RESP_SLVERR |-> rdata == '0)
    else $error("Unmapped read returned nonzero data.");

  imask_write_a: assert property (
    ce && wr_imsk |=> irq_mask == $past(wcmd.data[`FAGM_GRP_N-1:0]))
    else $error("Interrupt mask did not take the written value.");

  status_sticky_a: assert property (
    ce && !wr_ist |=> (irq_status & $past(irq_status)) == $past(irq_status))
    else $error("Interrupt status bit cleared without a write.");

  status_clear_a: assert property (
    ce && wr_ist |=> (irq_status & $past(w1c) & ~$past(new_ev)) == '0)
    else $error("Written status bit was not cleared.");

  masked_fault_c: cover property (
    ce && grp_active != '0
    && (grp_active & ~fault_alert_mask_primary) == '0 ##1 !fault_alert_req);

  alert_rise_c: cover property (!fault_alert_req ##1 fault_alert_req);

  irq_clear_c: cover property (irq ##1 ce && wr_ist ##1 !irq);

  slverr_c: cover property (bvalid && bresp == `FAGM_RESP_SLVERR);

  power_merge_c: cover property (
    ce && (|faults.power_fault_status_two) ##2 fault_alert_req);

endmodule : fagm_top
`default_nettype wire

/* File: bench/fagm_host_monitor.sv */
// Host side model that watches the active low fault alert pin.
`default_nettype none
module fagm_host_monitor (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fault_alert_pin_n,
  output logic [15:0] alert_count
);
  timeunit 1ns;
  timeprecision 1ps;

  logic pin_last;

  // The host only counts new alerts, so a pin held low counts once.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_last <= 1'b1;
      alert_count <= 16'h0000;
    end else begin
      pin_last <= fault_alert_pin_n;
      if (pin_last && !fault_alert_pin_n) begin
        alert_count <= alert_count + 16'h0001;
      end
    end
  end
endmodule : fagm_host_monitor
`default_nettype wire

/* File: bench/testbench.sv */
// Self-checking testbench for the fault alert group masking block.
`default_nettype none
`include "fagm_defines.svh"
module testbench
  import fagm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] A_MASK = `FAGM_MASK_IDX << 2;
  localparam logic [15:0] A_ACT = `FAGM_ACT_IDX << 2;
  localparam logic [15:0] A_IST = `FAGM_IST_IDX << 2;
  localparam logic [15:0] A_IMSK = `FAGM_IMSK_IDX << 2;

  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic ce = 1'b1;
  logic [15:0] awaddr = 16'h0000, araddr = 16'h0000;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  fagm_fault_s faults = '0;
  logic fault_alert_req, fault_alert_pin_n, irq;
  logic [15:0] alert_count;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;

  always #4 aclk = ~aclk;

  fagm_top dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .faults(faults), .fault_alert_req(fault_alert_req),
    .fault_alert_pin_n(fault_alert_pin_n), .irq(irq));

  fagm_host_monitor host (.aclk(aclk), .aresetn(aresetn),
    .fault_alert_pin_n(fault_alert_pin_n), .alert_count(alert_count));

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  always @(posedge aclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      $display("BAD run length expected finish seen hang");
      print_verdict;
    end
  end

  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  // Handshakes are judged at the falling edge, where ready is settled.
  task automatic axw(input logic [15:0] a, input logic [31:0] d,
                     output logic [1:0] r);
    int n;
    logic ah, wh, bh;
    n = 0;
    bh = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bh) begin
      @(negedge aclk);
      ah = awvalid && awready;
      wh = wvalid && wready;
      bh = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      n++;
    end
    bready <= 1'b0;
    // Beats taken at edge 1, commit at edge 2, response taken at edge 3.
    chk("write latency", n, 32'd3);
  endtask : axw

  task automatic axr(input logic [15:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    int n;
    logic ah, rh;
    n = 0;
    rh = 1'b0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!rh) begin
      @(negedge aclk);
      ah = arvalid && arready;
      rh = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ah) arvalid <= 1'b0;
      n++;
    end
    rready <= 1'b0;
    chk("read latency", n, 32'd2);
  endtask : axr

  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk("write response", {30'h0, r}, {30'h0, `FAGM_RESP_OKAY});
  endtask : wr

  task automatic rdchk(input string what, input logic [15:0] a,
                       input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk(what, d, exp);
    chk("read response", {30'h0, r}, {30'h0, `FAGM_RESP_OKAY});
  endtask : rdchk

  task automatic settle;
    repeat (2) @(posedge aclk);
    @(negedge aclk);
  endtask : settle

  task automatic setf(input fagm_fault_s f);
    @(posedge aclk);
    faults <= f;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
  endtask : setf

  task automatic alrt(input string what, input logic exp);
    chk(what, {31'h0, fault_alert_req}, {31'h0, exp});
    chk("alert pin level", {31'h0, fault_alert_pin_n}, {31'h0, !exp});
  endtask : alrt

  function automatic fagm_fault_s one_fault(input int k);
    fagm_fault_s f;
    f = '0;
    case (k)
      0: f.protector_fault_status = 16'h8000;
      1: f.undertemp_fault_status = 8'h01;
      2: f.overtemp_fault_status = 8'h10;
      3: f.undervolt_fault_status = 8'h80;
      4: f.overvolt_fault_status = 8'h02;
      5: f.compare_diag_fault_status = 8'h40;
      6: f.system_fault_status = 8'h01;
      7: f.power_fault_status_one = 8'h01;
      8: f.power_fault_status_two = 8'h08;
      9: f.power_fault_status_three = 8'h80;
      default: f = '0;
    endcase
    return f;
  endfunction : one_fault

  task automatic t_reset;
    logic [31:0] d;
    logic [1:0] r;
    alrt("alert after reset", 1'b0);
    chk("irq after reset", {31'h0, irq}, 32'h0);
    rdchk("mask reset", A_MASK, {24'h0, `FAGM_MASK_RST});
    rdchk("status reset", A_IST, {24'h0, `FAGM_IST_RST});
    rdchk("irq mask reset", A_IMSK, {24'h0, `FAGM_IMSK_RST});
    wr(A_MASK, 32'h0000_00a5);
    rdchk("mask read back", A_MASK, 32'h0000_00a5);
    axr(16'h007c, d, r);
    chk("unmapped read data", d, 32'h0);
    chk("unmapped read resp", {30'h0, r}, {30'h0, `FAGM_RESP_SLVERR});
    axw(16'h007c, 32'h0000_00ff, r);
    chk("unmapped write resp", {30'h0, r}, {30'h0, `FAGM_RESP_SLVERR});
    wr(A_MASK, 32'h0);
    $display("test reset and registers done");
  endtask : t_reset

  // Each fault register is opened alone, then its own mask bit is set.
  task automatic t_groups;
    logic [7:0] g;
    logic [15:0] seen;
    for (int k = 0; k < 10; k++) begin
      g = 8'h01 << ((k < 7) ? 7 - k : 0);
      seen = alert_count;
      wr(A_MASK, 32'h0);
      setf(one_fault(k));
      alrt("unmasked group alert", 1'b1);
      chk("host saw alert", {16'h0, alert_count}, {16'h0, seen + 16'h1});
      rdchk("group active", A_ACT, {24'h0, g});
      wr(A_MASK, {24'h0, g});
      settle;
      alrt("own mask bit set", 1'b0);
      rdchk("group kept active", A_ACT, {24'h0, g});
      wr(A_MASK, {24'h0, ~g});
      settle;
      alrt("other bits masked", 1'b1);
      setf('0);
      alrt("fault gone", 1'b0);
    end
    $display("test per group masking done");
  endtask : t_groups

  task automatic t_merge;
    fagm_fault_s f;
    f = one_fault(1);
    f.system_fault_status = 8'h04;
    wr(A_MASK, 32'h0);
    setf(f);
    wr(A_MASK, 32'h0000_0002);
    settle;
    alrt("second group holds alert", 1'b1);
    wr(A_MASK, 32'h0000_0042);
    settle;
    alrt("both masked", 1'b0);
    rdchk("both still active", A_ACT, 32'h0000_0042);
    wr(A_MASK, 32'h0);
    settle;
    alrt("mask removed", 1'b1);
    setf('0);
    $display("test merge of groups done");
  endtask : t_merge

  task automatic t_irq;
    wr(A_IST, 32'h0000_00ff);
    rdchk("status cleared", A_IST, 32'h0);
    wr(A_IMSK, 32'h0000_0002);
    setf(one_fault(6));
    chk("irq raised", {31'h0, irq}, 32'h1);
    setf('0);
    chk("irq sticky", {31'h0, irq}, 32'h1);
    rdchk("status sticky", A_IST, 32'h0000_0002);
    wr(A_IST, 32'h0000_0002);
    @(negedge aclk);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    wr(A_IMSK, 32'h0);
    setf(one_fault(1));
    rdchk("status set while masked", A_IST, 32'h0000_0040);
    chk("irq masked", {31'h0, irq}, 32'h0);
    setf('0);
    $display("test interrupt done");
  endtask : t_irq

  // A frozen block must neither see a new fault nor move its alert.
  task automatic t_freeze;
    @(posedge aclk);
    ce <= 1'b0;
    faults <= one_fault(4);
    repeat (4) @(posedge aclk);
    @(negedge aclk);
    alrt("alert frozen", 1'b0);
    chk("ready frozen", {31'h0, arready}, 32'h0);
    @(posedge aclk);
    ce <= 1'b1;
    repeat (3) @(posedge aclk);
    @(negedge aclk);
    alrt("alert after thaw", 1'b1);
    setf('0);
    $display("test clock enable freeze done");
  endtask : t_freeze

  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    t_reset;
    t_groups;
    t_merge;
    t_irq;
    t_freeze;
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
